// file: design/pm_smi_pkg.sv
// Shared constants and carrier types of the power-management event block
package pm_smi_pkg;

  // ----------------------------------------------------------------
  // Clock and step periods of the monitor standby timer
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned SLOT_6600MS_US = 6600000;
  localparam int unsigned SLOT_840MS_US = 840000;
  localparam int unsigned SLOT_13300US_US = 13300;
  localparam int unsigned SLOT_1600US_US = 1600;
  localparam int unsigned SLOT_6600MS_CYC = SLOT_6600MS_US * CLK_MHZ;
  localparam int unsigned SLOT_840MS_CYC = SLOT_840MS_US * CLK_MHZ;
  localparam int unsigned SLOT_13300US_CYC = SLOT_13300US_US * CLK_MHZ;
  localparam int unsigned SLOT_1600US_CYC = SLOT_1600US_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_SW_TRIGGER = 8'h60;
  localparam logic [7:0] IDX_EVENT_ENABLE = 8'h68;
  localparam logic [7:0] IDX_REQUEST_STATUS = 8'h69;
  localparam logic [7:0] IDX_MON_CTRL = 8'h6A;
  localparam logic [7:0] IDX_MON_TIMER_LO = 8'h6B;
  localparam logic [7:0] IDX_MON_TIMER_HI = 8'h6C;
  localparam logic [7:0] IDX_PORT16_LO = 8'h6D;
  localparam logic [7:0] IDX_PORT16_HI = 8'h6E;
  localparam logic [7:0] IDX_STBY_MASK = 8'h6F;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SW_TRIG_BIT = 1;
  localparam int REQ_PORT16 = 5;
  localparam int REQ_SERIAL = 4;
  localparam int REQ_PARALLEL = 3;
  localparam int REQ_HDD = 2;
  localparam int REQ_BREAK = 1;
  localparam int REQ_SOFT = 0;
  localparam int CTL_MSTBY_EN = 7;
  localparam int CTL_MSTBY_REQ = 6;
  localparam int CTL_MWAKE_EN = 5;
  localparam int CTL_MWAKE_REQ = 4;
  localparam int CTL_THR_REQ = 3;
  localparam int CTL_THR_EN = 2;
  localparam int CTL_SWAKE_EN = 1;
  localparam int CTL_SWAKE_REQ = 0;
  localparam int MSK_BUS_RETURN = 7;
  localparam int MSK_APP_OUT = 6;
  localparam int MSK_TRAP_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values and write-one-to-clear lanes
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] CTL_W1C = 8'h59;
  localparam logic [5:0] STATUS_W1C = 6'h3F;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Pins from outside the clock domain
  typedef struct packed {
    logic [15:1] irq;
    logic hold;
    logic nmi;
    logic init;
    logic break_n;
    logic sys_io_bus_request_n_n;
  } pm_pins_t;

  localparam pm_pins_t PINS_IDLE = '{irq: 15'h0000, hold: 1'b0, nmi: 1'b0, init: 1'b0,
                                      break_n: 1'b1, sys_io_bus_request_n_n: 1'b1};

  // State of the main block, apart from the pin synchroniser and the step timebase
  typedef struct packed {
    logic [7:0] enable;
    logic [5:0] status;
    logic [7:0] ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    logic running;
    logic mon_standby;
    logic [15:0] port16;
    logic [7:0] mask;
    pm_pins_t prev;
    logic bus_return;
    logic port16_hit;
    logic sys_reload;
    logic mgmt_n;
    logic [31:0] prdata;
  } pm_state_t;

endpackage : pm_smi_pkg

// file: design/pm_sync2.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/100ps
`default_nettype none
module pm_sync2 #(
  parameter int WIDTH = 20,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Asynchronous pins in, synchronised copy out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // Both stages in one state word; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // Next state
  always_comb begin
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{meta: RST_VAL, stable: RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule : pm_sync2
`default_nettype wire

// file: design/pm_step_timebase.sv
// Step-period divider for the monitor standby timer
`timescale 1ns/100ps
`default_nettype none
module pm_step_timebase #(
  parameter int unsigned PERIOD0 = 1000,
  parameter int unsigned PERIOD1 = 500,
  parameter int unsigned PERIOD2 = 100,
  parameter int unsigned PERIOD3 = 50
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic restart,
  input wire logic [1:0] slot_sel,
  // One-cycle step pulse
  output logic tick
);

  // Divider state
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tb_state_t;

  tb_state_t s_q;
  tb_state_t s_d;
  logic [31:0] last;

  // Terminal count of the selected slot
  always_comb begin
    unique case (slot_sel)
      2'b00: last = 32'(PERIOD0 - 1);
      2'b01: last = 32'(PERIOD1 - 1);
      2'b10: last = 32'(PERIOD2 - 1);
      2'b11: last = 32'(PERIOD3 - 1);
    endcase
  end

  // Count up, wrap and pulse; restart realigns the period
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart) begin
      s_d.cnt = 32'h0000_0000;
    end else if (s_q.cnt >= last) begin
      s_d.cnt = 32'h0000_0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{cnt: 32'h0000_0000, tick: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule : pm_step_timebase
`default_nettype wire

// file: design/power_mgmt_smi_events.sv
// Power-management event flags, management interrupt and monitor standby timer
//
// Behaviour
// R1: Serial port access sets serial wake flag
// R2: Parallel port access sets parallel wake flag
// R3: Hard disk access sets disk wake flag
// R4: Break switch press sets break flag
// R5: Write bit1 of trigger sets software flag
// R6: Monitor timer expiry raises interrupt when enabled
// R7: Expiry sets monitor standby flag; software clears
// R8: Monitor wake enable: activity raises interrupt
// R9: Activity in monitor standby sets wake flag
// R10: Event while throttling sets throttle wake flag
// R11: Throttle wake enable: event raises interrupt
// R12: System wake enable: event raises interrupt
// R13: Event in system standby sets wake flag
// R14: Timer counts down, four selectable step periods
// R15: Enabling timer loads programmed value, starts count
// R16: Activity before expiry reloads timer
// R17: Timer registers read live count
// R18: Timer is sixteen bits, two byte registers
// R19: Sixteen-bit port address detects port access
// R20: Unmasked trap event reloads system standby timer
// R21: Bus return bit hands bus back after request
// R22: Application output bit has no internal effect
// R23: Flags set only while their enable is set
// R24: Interrupt low while any enabled flag set
// R25: Step period chosen by two-bit input
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_smi_events
  import pm_smi_pkg::*;
#(
  parameter int unsigned SLOT0_CYCLES = SLOT_6600MS_CYC,
  parameter int unsigned SLOT1_CYCLES = SLOT_840MS_CYC,
  parameter int unsigned SLOT2_CYCLES = SLOT_13300US_CYC,
  parameter int unsigned SLOT3_CYCLES = SLOT_1600US_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous event pins
  input wire logic [15:1] interrupt_request_lines,
  input wire logic hold_request,
  input wire logic nmi_request,
  input wire logic init_request,
  input wire logic break_switch_n,
  input wire logic sys_io_bus_request_n,
  // Same-clock decode strobes from the I/O cycle logic
  input wire logic serial_port_hit,
  input wire logic parallel_port_hit,
  input wire logic hdd_port_hit,
  input wire logic io_cycle_valid,
  input wire logic [15:0] io_cycle_addr,
  input wire logic [3:0] standby_trap_hits,
  // System power state
  input wire logic system_in_standby,
  input wire logic system_in_throttle,
  input wire logic [1:0] monitor_slot_sel,
  // Outputs
  output logic mgmt_interrupt_n,
  output logic port16_hit,
  output logic sys_standby_reload,
  output logic return_bus_to_cpu,
  output logic application_output_bit,
  output logic monitor_in_standby
);

  // ----------------------------------------------------------------
  // Pin synchronisation and step timebase
  // ----------------------------------------------------------------
  pm_pins_t pins_raw; // Pins as they arrive
  pm_pins_t pins; // Pins after two flops
  logic tick; // One step of the monitor timer
  logic tb_restart; // Realign the step period

  assign pins_raw = '{irq: interrupt_request_lines, hold: hold_request, nmi: nmi_request,
                      init: init_request, break_n: break_switch_n,
                      sys_io_bus_request_n_n: sys_io_bus_request_n};

  pm_sync2 #(.WIDTH($bits(pm_pins_t)), .RST_VAL(PINS_IDLE)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  pm_step_timebase #(
    .PERIOD0(SLOT0_CYCLES),
    .PERIOD1(SLOT1_CYCLES),
    .PERIOD2(SLOT2_CYCLES),
    .PERIOD3(SLOT3_CYCLES)
  ) u_timebase (
    .pclk(pclk),
    .presetn(presetn),
    .restart(tb_restart),
    .slot_sel(monitor_slot_sel), // [R25]
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // State, events and bus decode
  // ----------------------------------------------------------------
  pm_state_t s_q; // Registered state
  pm_state_t s_d; // Next state
  logic mon_activity; // Edge on an interrupt line, hold or nmi
  logic sys_event; // Same plus init
  logic break_press; // Falling edge of the break switch
  logic bus_released; // Bus request just serviced
  logic timer_on; // Monitor timer enabled
  logic timer_load; // Timer just enabled
  logic expire; // Monitor timer reached its end
  logic [7:0] idx; // Register index
  logic mapped; // Address names a register
  logic wr; // Write takes effect this edge
  logic rd_setup; // Read setup cycle
  logic [7:0] wb; // Written byte
  logic [9:0] pending; // Flags with enables

  // Edges of synchronised pins: rising for the event pins and bus request, falling for the break switch
  always_comb begin
    mon_activity = (|(pins.irq & ~s_q.prev.irq)) | (pins.hold & ~s_q.prev.hold) |
                   (pins.nmi & ~s_q.prev.nmi);
    sys_event = mon_activity | (pins.init & ~s_q.prev.init);
    break_press = ~pins.break_n & s_q.prev.break_n;
    bus_released = pins.sys_io_bus_request_n_n & ~s_q.prev.sys_io_bus_request_n_n;
  end

  // Timer control terms
  always_comb begin
    timer_on = s_q.ctrl[CTL_MSTBY_EN];
    // Load on every enable, even when the count already equals the reload value
    timer_load = timer_on & ~s_q.running & ~s_q.mon_standby; // [R15]
    expire = timer_on & s_q.running & tick & (s_q.count == RST_WORD);
    tb_restart = timer_load | (mon_activity & timer_on);
  end

  // APB decode
  always_comb begin
    idx = paddr[9:2];
    wb = pwdata[7:0];
    unique case (idx)
      IDX_SW_TRIGGER, IDX_EVENT_ENABLE, IDX_REQUEST_STATUS, IDX_MON_CTRL, IDX_MON_TIMER_LO,
      IDX_MON_TIMER_HI, IDX_PORT16_LO, IDX_PORT16_HI, IDX_STBY_MASK: mapped = (paddr[1:0] == 2'b00);
      default: mapped = 1'b0;
    endcase
    wr = psel & penable & pwrite & mapped;
    rd_setup = psel & ~penable & ~pwrite;
  end

  // Enabled flags that hold the interrupt low
  always_comb begin
    pending[5:0] = s_q.status & s_q.enable[5:0];
    pending[6] = s_q.ctrl[CTL_MSTBY_REQ] & s_q.ctrl[CTL_MSTBY_EN];
    pending[7] = s_q.ctrl[CTL_MWAKE_REQ] & s_q.ctrl[CTL_MWAKE_EN];
    pending[8] = s_q.ctrl[CTL_THR_REQ] & s_q.ctrl[CTL_THR_EN];
    pending[9] = s_q.ctrl[CTL_SWAKE_REQ] & s_q.ctrl[CTL_SWAKE_EN];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.prev = pins;
    // Register writes; clears first so that a same-cycle set wins
    if (wr) begin
      unique case (idx)
        IDX_EVENT_ENABLE: s_d.enable = wb;
        IDX_REQUEST_STATUS: s_d.status = s_q.status & ~(wb[5:0] & STATUS_W1C);
        IDX_MON_CTRL: s_d.ctrl = (wb & ~CTL_W1C) | (s_q.ctrl & CTL_W1C & ~wb);
        IDX_MON_TIMER_LO: s_d.reload[7:0] = wb; // [R18]
        IDX_MON_TIMER_HI: s_d.reload[15:8] = wb; // [R18]
        IDX_PORT16_LO: s_d.port16[7:0] = wb; // [R19]
        IDX_PORT16_HI: s_d.port16[15:8] = wb; // [R19]
        IDX_STBY_MASK: s_d.mask = wb;
        default: s_d.enable = s_q.enable;
      endcase
    end
    // Device port wake and request flags
    if (serial_port_hit & s_q.enable[REQ_SERIAL]) begin
      s_d.status[REQ_SERIAL] = 1'b1; // [R1] [R23]
    end
    if (parallel_port_hit & s_q.enable[REQ_PARALLEL]) begin
      s_d.status[REQ_PARALLEL] = 1'b1; // [R2] [R23]
    end
    if (hdd_port_hit & s_q.enable[REQ_HDD]) begin
      s_d.status[REQ_HDD] = 1'b1; // [R3] [R23]
    end
    if (break_press & s_q.enable[REQ_BREAK]) begin
      s_d.status[REQ_BREAK] = 1'b1; // [R4] [R23]
    end
    if (wr & (idx == IDX_SW_TRIGGER) & wb[SW_TRIG_BIT] & s_q.enable[REQ_SOFT]) begin
      s_d.status[REQ_SOFT] = 1'b1; // [R5] [R23]
    end
    // Sixteen-bit port compare
    s_d.port16_hit = io_cycle_valid & (io_cycle_addr == s_q.port16); // [R19]
    if (s_d.port16_hit & s_q.enable[REQ_PORT16]) begin
      s_d.status[REQ_PORT16] = 1'b1;
    end
    // Monitor timer: load, reload, expire, count down
    if (!timer_on) begin
      s_d.running = 1'b0;
      s_d.mon_standby = 1'b0;
    end else if (timer_load) begin
      s_d.count = s_q.reload; // [R15]
      s_d.running = 1'b1;
    end else if (mon_activity) begin
      s_d.count = s_q.reload; // [R16]
      s_d.running = 1'b1;
    end else if (expire) begin
      s_d.running = 1'b0;
      s_d.mon_standby = 1'b1;
      s_d.ctrl[CTL_MSTBY_REQ] = 1'b1; // [R7] [R6]
    end else if (s_q.running & tick) begin
      s_d.count = s_q.count - 16'h0001; // [R14]
    end
    // Monitor wake
    if (mon_activity & s_q.mon_standby & s_q.ctrl[CTL_MWAKE_EN]) begin
      s_d.ctrl[CTL_MWAKE_REQ] = 1'b1; // [R9] [R8]
    end
    if (mon_activity) begin
      s_d.mon_standby = 1'b0;
    end
    // System wake from throttling and from standby
    if (sys_event & system_in_throttle & s_q.ctrl[CTL_THR_EN]) begin
      s_d.ctrl[CTL_THR_REQ] = 1'b1; // [R10] [R11]
    end
    if (sys_event & system_in_standby & s_q.ctrl[CTL_SWAKE_EN]) begin
      s_d.ctrl[CTL_SWAKE_REQ] = 1'b1; // [R13] [R12]
    end
    // System standby timer reload request
    s_d.sys_reload = |(standby_trap_hits & s_q.mask[MSK_TRAP_LSB +: 4]); // [R20]
    // Hand the bus back once the request is released
    s_d.bus_return = bus_released & s_q.mask[MSK_BUS_RETURN]; // [R21]
    // Interrupt follows enabled flags
    s_d.mgmt_n = ~(|pending); // [R24] [R6] [R8] [R11] [R12]
    // Read data captured in the setup cycle
    if (rd_setup) begin
      s_d.prdata = 32'h0000_0000;
      unique case (idx)
        IDX_EVENT_ENABLE: s_d.prdata[7:0] = s_q.enable;
        IDX_REQUEST_STATUS: s_d.prdata[5:0] = s_q.status;
        IDX_MON_CTRL: s_d.prdata[7:0] = s_q.ctrl;
        IDX_MON_TIMER_LO: s_d.prdata[7:0] = s_q.count[7:0]; // [R17]
        IDX_MON_TIMER_HI: s_d.prdata[7:0] = s_q.count[15:8]; // [R17]
        IDX_PORT16_LO: s_d.prdata[7:0] = s_q.port16[7:0];
        IDX_PORT16_HI: s_d.prdata[7:0] = s_q.port16[15:8];
        IDX_STBY_MASK: s_d.prdata[7:0] = s_q.mask;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{enable: RST_BYTE, status: 6'h00, ctrl: RST_BYTE, reload: RST_WORD,
               count: RST_WORD, running: 1'b0, mon_standby: 1'b0, port16: RST_WORD,
               mask: RST_BYTE, prev: PINS_IDLE, bus_return: 1'b0, port16_hit: 1'b0,
               sys_reload: 1'b0, mgmt_n: 1'b1, prdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata = s_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign mgmt_interrupt_n = s_q.mgmt_n;
  assign port16_hit = s_q.port16_hit;
  assign sys_standby_reload = s_q.sys_reload;
  assign return_bus_to_cpu = s_q.bus_return;
  assign application_output_bit = s_q.mask[MSK_APP_OUT]; // [R22]
  assign monitor_in_standby = s_q.mon_standby;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_serial_flag;
    @(posedge pclk) disable iff (!presetn)
      serial_port_hit & s_q.enable[REQ_SERIAL] |=> s_q.status[REQ_SERIAL];
  endproperty
  a_serial_flag: assert property (p_serial_flag) else $error("serial flag not set"); // [R1]

  property p_hdd_flag_gated;
    @(posedge pclk) disable iff (!presetn)
      !s_q.enable[REQ_HDD] & !s_q.status[REQ_HDD] |=> !s_q.status[REQ_HDD];
  endproperty
  a_hdd_flag_gated: assert property (p_hdd_flag_gated) else $error("disk flag set unenabled"); // [R23]

  property p_soft_flag;
    @(posedge pclk) disable iff (!presetn)
      wr & (idx == IDX_SW_TRIGGER) & wb[SW_TRIG_BIT] & s_q.enable[REQ_SOFT] |=> s_q.status[REQ_SOFT];
  endproperty
  a_soft_flag: assert property (p_soft_flag) else $error("software flag not set"); // [R5]

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      ##1 (mgmt_interrupt_n == !(|$past(pending)));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt does not follow flags"); // [R24]

  property p_reload_on_activity;
    @(posedge pclk) disable iff (!presetn)
      timer_on & !timer_load & mon_activity |=> s_q.count == $past(s_q.reload);
  endproperty
  a_reload_on_activity: assert property (p_reload_on_activity) else $error("no reload"); // [R16]

  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
      timer_on & s_q.running & tick & !mon_activity & !timer_load & (s_q.count != 16'h0000)
      |=> s_q.count == $past(s_q.count) - 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step down"); // [R14]

  property p_live_read;
    @(posedge pclk) disable iff (!presetn)
      rd_setup & (idx == IDX_MON_TIMER_LO) |=> prdata[7:0] == $past(s_q.count[7:0]);
  endproperty
  a_live_read: assert property (p_live_read) else $error("timer read not live"); // [R17]

  property p_expiry_irq;
    @(posedge pclk) disable iff (!presetn)
      expire |-> ##2 !mgmt_interrupt_n;
  endproperty
  a_expiry_irq: assert property (p_expiry_irq) else $error("expiry gave no interrupt"); // [R6]

  property p_mon_wake;
    @(posedge pclk) disable iff (!presetn)
      mon_activity & s_q.mon_standby & s_q.ctrl[CTL_MWAKE_EN] |=> s_q.ctrl[CTL_MWAKE_REQ];
  endproperty
  a_mon_wake: assert property (p_mon_wake) else $error("monitor wake flag missing"); // [R9]

  property p_sys_wake;
    @(posedge pclk) disable iff (!presetn)
      sys_event & system_in_standby & s_q.ctrl[CTL_SWAKE_EN] |=> s_q.ctrl[CTL_SWAKE_REQ];
  endproperty
  a_sys_wake: assert property (p_sys_wake) else $error("system wake flag missing"); // [R13]

  property p_app_bit;
    @(posedge pclk) disable iff (!presetn)
      wr & (idx == IDX_STBY_MASK) |=> application_output_bit == $past(wb[MSK_APP_OUT]);
  endproperty
  a_app_bit: assert property (p_app_bit) else $error("application bit mismatch"); // [R22]

  property p_bus_return;
    @(posedge pclk) disable iff (!presetn)
      return_bus_to_cpu |-> $past(bus_released) & $past(s_q.mask[MSK_BUS_RETURN]);
  endproperty
  a_bus_return: assert property (p_bus_return) else $error("bus returned without cause"); // [R21]

  c_expire: cover property (@(posedge pclk) disable iff (!presetn) expire);
  c_irq_low: cover property (@(posedge pclk) disable iff (!presetn) $fell(mgmt_interrupt_n));
  c_mon_wake: cover property (@(posedge pclk) disable iff (!presetn)
                              $rose(s_q.ctrl[CTL_MWAKE_REQ]));
  c_bus_return: cover property (@(posedge pclk) disable iff (!presetn) return_bus_to_cpu);

endmodule : power_mgmt_smi_events
`default_nettype wire

// file: sim/pm_event_src.sv
// Partner model: legacy event sources, break switch and bus request
`timescale 1ns/100ps
`default_nettype none
module pm_event_src
  import pm_smi_pkg::*;
(
  // Clock and request
  input wire logic pclk,
  input wire logic go,
  input wire logic [2:0] src,
  // Pins toward the block
  output var pm_pins_t pins
);
  logic [2:0] cnt_q = 3'h0; // Cycles left in the pulse
  logic [2:0] src_q = 3'h0; // Source being pulsed
  // Hold a source for four cycles so the pin sync sees it
  always @(posedge pclk) begin
    if (go) begin
      cnt_q <= 3'h4;
      src_q <= src;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  // Idle levels outside a pulse
  always_comb begin
    pins = PINS_IDLE;
    if (cnt_q != 3'h0) begin
      case (src_q)
        3'h0: pins.irq[1] = 1'h1;
        3'h1: pins.hold = 1'h1;
        3'h2: pins.nmi = 1'h1;
        3'h3: pins.init = 1'h1;
        3'h4: pins.break_n = 1'h0;
        default: pins.sys_io_bus_request_n_n = 1'h0;
      endcase
    end
  end
endmodule : pm_event_src
`default_nettype wire

// file: sim/power_mgmt_smi_events_tb.sv
// Self-checking bench of the power-management event block
`timescale 1ns/100ps
`default_nettype none
module power_mgmt_smi_events_tb
  import pm_smi_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0; // Clock and reset
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // APB request
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, mgmt_n, p16, rld, ret, app, mstby;
  logic iov = 1'h0, thr = 1'h0, stby = 1'h0, go = 1'h0;
  logic [2:0] hits = 3'h0, src = 3'h0, seen = 3'h0; // Strobes, source, pulses seen
  logic [3:0] trap = 4'h0;
  logic [1:0] slot = 2'h2; // Monitor step period select
  pm_pins_t pins;
  int miscompares = 0, samples_checked = 0;
  always #2.5 pclk = ~pclk;
  // Remember single-cycle output pulses
  always @(posedge pclk) seen <= presetn ? (seen | {p16, rld, ret}) : 3'h0;
  pm_event_src ev_u (.pclk(pclk), .go(go), .src(src), .pins(pins));
  power_mgmt_smi_events #(.SLOT0_CYCLES(40), .SLOT1_CYCLES(20), .SLOT2_CYCLES(8),
    .SLOT3_CYCLES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interrupt_request_lines(pins.irq), .hold_request(pins.hold), .nmi_request(pins.nmi),
    .init_request(pins.init), .break_switch_n(pins.break_n),
    .sys_io_bus_request_n(pins.sys_io_bus_request_n_n), .serial_port_hit(hits[2]),
    .parallel_port_hit(hits[1]), .hdd_port_hit(hits[0]), .io_cycle_valid(iov),
    .io_cycle_addr(16'h1234), .standby_trap_hits(trap), .system_in_standby(stby),
    .system_in_throttle(thr), .monitor_slot_sel(slot), .mgmt_interrupt_n(mgmt_n),
    .port16_hit(p16), .sys_standby_reload(rld), .return_bus_to_cpu(ret),
    .application_output_bit(app), .monitor_in_standby(mstby));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n == 16) miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'h0, idx, 8'h00);
    chk(nm, rd, exp);
  endtask : rc
  task automatic pulse(input logic [2:0] h, input logic v, input logic [3:0] t);
    @(posedge pclk);
    hits <= h;
    iov <= v;
    trap <= t;
    @(posedge pclk);
    hits <= 3'h0;
    iov <= 1'h0;
    trap <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask : pulse
  task automatic fire(input logic [2:0] s);
    @(posedge pclk);
    go <= 1'h1;
    src <= s;
    @(posedge pclk);
    go <= 1'h0;
    repeat (10) @(posedge pclk);
  endtask : fire
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    rc("ctrl", IDX_MON_CTRL, 32'h0);
    rc("unmapped", 8'h61, 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    pulse(3'h7, 1'h0, 4'h0);
    rc("status", IDX_REQUEST_STATUS, 32'h0);
    apb(1'h1, IDX_EVENT_ENABLE, 8'h3F);
    pulse(3'h7, 1'h0, 4'h0);
    rc("status", IDX_REQUEST_STATUS, 32'h1C);
    chk("mgmt", {31'h0, mgmt_n}, 32'h0);
    apb(1'h1, IDX_SW_TRIGGER, 8'h02);
    fire(3'h4);
    apb(1'h1, IDX_PORT16_LO, 8'h34);
    apb(1'h1, IDX_PORT16_HI, 8'h12);
    pulse(3'h0, 1'h1, 4'h0);
    rc("status", IDX_REQUEST_STATUS, 32'h3F);
    apb(1'h1, IDX_REQUEST_STATUS, 8'h3F);
    repeat (2) @(posedge pclk);
    chk("mgmt", {31'h0, mgmt_n}, 32'h1);
    $display("Event flag test done");
    apb(1'h1, IDX_STBY_MASK, 8'hC4);
    rc("mask", IDX_STBY_MASK, 32'hC4);
    pulse(3'h0, 1'h0, 4'h1);
    fire(3'h5);
    chk("pulses", {29'h0, seen}, 32'h7);
    chk("app", {31'h0, app}, 32'h1);
    $display("Mask test done");
    apb(1'h1, IDX_MON_TIMER_LO, 8'h03);
    apb(1'h1, IDX_MON_TIMER_HI, 8'h00);
    apb(1'h1, IDX_MON_CTRL, 8'h80);
    repeat (12) @(posedge pclk);
    fire(3'h0);
    repeat (14) @(posedge pclk);
    rc("ctrl", IDX_MON_CTRL, 32'h80);
    repeat (30) @(posedge pclk);
    rc("ctrl", IDX_MON_CTRL, 32'hC0);
    rc("count", IDX_MON_TIMER_LO, 32'h0);
    chk("mstby", {31'h0, mstby}, 32'h1);
    apb(1'h1, IDX_MON_CTRL, 8'hE0);
    fire(3'h1);
    rc("ctrl", IDX_MON_CTRL, 32'hB0);
    $display("Monitor timer test done");
    apb(1'h1, IDX_MON_CTRL, 8'h5F);
    thr <= 1'h1;
    fire(3'h2);
    thr <= 1'h0;
    stby <= 1'h1;
    fire(3'h3);
    rc("ctrl", IDX_MON_CTRL, 32'h0F);
    chk("mgmt", {31'h0, mgmt_n}, 32'h0);
    $display("Wake test done");
    // Shortest step: expiry well before the 8-cycle slot 2 would reach it
    slot <= 2'h3;
    apb(1'h1, IDX_MON_CTRL, 8'h89);
    repeat (20) @(posedge pclk);
    rc("ctrl", IDX_MON_CTRL, 32'hC0);
    $display("Slot test done");
    end_sim;
  end
  // Watchdog against a hang
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    end_sim;
  end
endmodule : power_mgmt_smi_events_tb
`default_nettype wire
